/* File: rci_defs.vh */
// constants for the remote contact input and interlock block
`ifndef RCI_DEFS_VH
`define RCI_DEFS_VH

`define RCI_CLK_PERIOD_NS     4
`define RCI_DEBOUNCE_NS       1000000
`define RCI_DEBOUNCE_CYC      (`RCI_DEBOUNCE_NS / `RCI_CLK_PERIOD_NS)
`define RCI_WARN_TIME_S       2
`define RCI_WARN_CYC          (`RCI_WARN_TIME_S * 1000000000 / `RCI_CLK_PERIOD_NS)
`define RCI_BEEP_NS           100000000
`define RCI_BEEP_CYC          (`RCI_BEEP_NS / `RCI_CLK_PERIOD_NS)
`define RCI_BEEP_COUNT        2
`define RCI_CNT_W             32
`define RCI_SLOT_W            3
`define RCI_PROG_W            6
`define RCI_LOCAL_MAX         6'h32
`define RCI_STATUS_TEST_REQ   0
`define RCI_STATUS_RESET_REQ  1
`define RCI_STATUS_IL_OPEN    2
`define RCI_STATUS_ABORT      3
`define RCI_STATUS_W          4

`endif

/* File: rci_debounce.v */
// synchroniser and debouncer for one contact input
`include "rci_defs.vh"
module rci_debounce #(
    parameter [31:0] STABLE_CYC = `RCI_DEBOUNCE_CYC
) (
    // clock and reset
    input  wire core_clk_i,
    input  wire rst_n_i,
    // contact, high while closed
    input  wire raw_i,
    // debounced level and closure pulse
    output reg  level_o,
    output reg  rise_o
);
    reg        sync1_reg;
    reg        sync2_reg;
    reg [31:0] cnt_reg;

    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            cnt_reg   <= 32'h0000_0000;
            level_o   <= 1'b0;
            rise_o    <= 1'b0;
        end else begin
            sync1_reg <= raw_i;
            sync2_reg <= sync1_reg;
            rise_o    <= 1'b0;
            if (sync2_reg == level_o) begin
                cnt_reg <= 32'h0000_0000;
            end else if (cnt_reg >= STABLE_CYC - 32'h0000_0001) begin
                cnt_reg <= 32'h0000_0000;
                level_o <= sync2_reg;
                rise_o  <= sync2_reg;  // one pulse per closure edge
            end else begin
                cnt_reg <= cnt_reg + 32'h0000_0001;
            end
        end
    end
endmodule // rci_debounce

/* File: rci_timer.v */
// loadable down counter with expiry pulse
`include "rci_defs.vh"
module rci_timer (
    // clock and reset
    input  wire        core_clk_i,
    input  wire        rst_n_i,
    // control
    input  wire        load_i,
    input  wire        stop_i,
    input  wire [31:0] value_i,
    // state
    output reg         busy_o,
    output reg         done_o
);
    reg [31:0] cnt_reg;

    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 32'h0000_0000;
            busy_o  <= 1'b0;
            done_o  <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (stop_i) begin
                busy_o <= 1'b0;
            end else if (load_i) begin
                cnt_reg <= value_i;
                busy_o  <= 1'b1;
            end else if (busy_o) begin
                if (cnt_reg <= 32'h0000_0001) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - 32'h0000_0001;
                end
            end
        end
    end
endmodule // rci_timer

/* File: rci_top.v */
// remote contact input front end: test, reset, interlock and program select
//
// Behaviour
// - remote test, reset and select ignored unless remote contact control enabled
// - on enabling in reset state: light indicator, beep twice, reset on front key once the tone sequence ends
// - abnormal condition cleared by local reset key or remote reset
// - momentary test contact closure is a test start command
// - momentary reset contact closure is a reset command
// - interlock is normally open, must be held closed to enable output
// - three select lines form binary value, weight four on top, zero none
// - remote select reaches only programs one to seven of fifty
// - open interlock keeps output disabled as a failure
// - test refused with open interlock, warning shown two seconds
// - interlock opening mid-test aborts test, disables output, warns
// - nothing connected means no test and no output
`include "rci_defs.vh"
module rci_top #(
    parameter [31:0] DEBOUNCE_CYC = `RCI_DEBOUNCE_CYC,
    parameter [31:0] WARN_CYC     = `RCI_WARN_CYC,
    parameter [31:0] BEEP_CYC     = `RCI_BEEP_CYC
) (
    // clock and reset
    input  wire                     core_clk_i,
    input  wire                     rst_n_i,
    // contact inputs, high while closed to common
    input  wire                     test_contact_i,
    input  wire                     reset_contact_i,
    input  wire                     interlock_contact_i,
    input  wire [`RCI_SLOT_W-1:0]   select_contact_i,
    // configuration and front panel
    input  wire                     remote_contact_control_enable_i,
    input  wire                     front_key_i,
    input  wire                     local_test_key_i,
    input  wire                     local_reset_key_i,
    input  wire [`RCI_PROG_W-1:0]   local_program_i,
    // system events
    input  wire                     test_complete_i,
    input  wire                     fault_detect_i,
    // status/mask register port
    input  wire                     reg_addr_i,
    input  wire [`RCI_STATUS_W-1:0] reg_wdata_i,
    input  wire                     reg_wr_i,
    input  wire                     reg_rd_i,
    output reg  [`RCI_STATUS_W-1:0] reg_rdata_o,
    // outputs
    output reg                      output_enable_o,
    output reg                      test_running_o,
    output reg                      fault_o,
    output reg                      warn_msg_o,
    output reg                      indicator_o,
    output reg                      buzzer_o,
    output reg  [`RCI_PROG_W-1:0]   program_sel_o,
    output reg                      irq_o
);
    localparam [1:0] ST_RESET = 2'h0;
    localparam [1:0] ST_TEST  = 2'h1;
    localparam [1:0] ST_FAULT = 2'h2;
    localparam [1:0] ST_ANNC  = 2'h3;

    wire                   test_lvl;
    wire                   test_rise;
    wire                   rst_lvl;
    wire                   rst_rise;
    wire                   il_closed;
    wire [`RCI_SLOT_W-1:0] sel_lvl;
    wire                   warn_busy;
    wire                   beep_busy;
    wire                   beep_done;

    reg  [1:0]                state_reg;
    reg  [1:0]                state_next;
    reg                       en_d_reg;
    reg  [1:0]                beep_cnt_reg;
    reg                       beep_on_reg;
    reg  [`RCI_STATUS_W-1:0]  status_reg;
    reg  [`RCI_STATUS_W-1:0]  mask_reg;
    reg  [`RCI_STATUS_W-1:0]  events;
    reg                       start_req;
    reg                       reset_req;
    reg                       refuse;
    reg                       abort;

    // remote select value to program number
    function [`RCI_PROG_W-1:0] slot_to_prog;
        input [`RCI_SLOT_W-1:0] slot;
        begin
            slot_to_prog = {3'h0, slot};
        end
    endfunction

    rci_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_db_test (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .raw_i(test_contact_i),
        .level_o(test_lvl), .rise_o(test_rise));
    rci_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_db_rst (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .raw_i(reset_contact_i),
        .level_o(rst_lvl), .rise_o(rst_rise));
    // unplugged connector reads open, so interlock holds off test start and output
    rci_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_db_il (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .raw_i(interlock_contact_i),
        .level_o(il_closed), .rise_o());
    genvar gi;
    generate
        for (gi = 0; gi < `RCI_SLOT_W; gi = gi + 1) begin : g_sel
            rci_debounce #(.STABLE_CYC(DEBOUNCE_CYC)) u_db_sel (
                .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .raw_i(select_contact_i[gi]),
                .level_o(sel_lvl[gi]), .rise_o());
        end
    endgenerate

    always @* begin
        // remote edges count only while enabled
        start_req = local_test_key_i | (remote_contact_control_enable_i & test_rise);
        reset_req = local_reset_key_i | (remote_contact_control_enable_i & rst_rise);
        refuse    = start_req & !il_closed & (state_reg == ST_RESET);
        abort     = (state_reg == ST_TEST) & !il_closed;
        state_next = state_reg;
        case (state_reg)
            ST_RESET: begin
                if (remote_contact_control_enable_i & !en_d_reg) begin
                    state_next = ST_ANNC;
                end else if (start_req & il_closed & !reset_req) begin
                    state_next = ST_TEST;
                end
            end
            ST_TEST: begin
                if (abort | fault_detect_i) begin
                    state_next = ST_FAULT;
                end else if (reset_req | test_complete_i) begin
                    state_next = ST_RESET;
                end
            end
            ST_FAULT: begin
                if (reset_req) begin
                    state_next = ST_RESET;
                end
            end
            ST_ANNC: begin
                // wait for the whole tone sequence, or a key in a gap would cut it short
                if (front_key_i & !beep_busy & !beep_on_reg & (beep_cnt_reg == 2'h0)) begin
                    state_next = ST_RESET;
                end
            end
            default: begin
                state_next = ST_RESET;
            end
        endcase
        events = {abort, !il_closed, reset_req, start_req};
    end

    rci_timer u_warn (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .load_i(refuse | abort), .stop_i(1'b0), .value_i(WARN_CYC),
        .busy_o(warn_busy), .done_o());

    // one timer paces both beeps and the gap between them
    rci_timer u_beep (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .load_i((state_reg == ST_RESET && state_next == ST_ANNC) || (beep_done && beep_cnt_reg != 2'h0)),
        .stop_i(state_next != ST_ANNC), .value_i(BEEP_CYC),  // no stray tone once announce is left
        .busy_o(beep_busy), .done_o(beep_done));

    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg       <= ST_RESET;
            en_d_reg        <= 1'b0;
            beep_cnt_reg    <= 2'h0;
            beep_on_reg     <= 1'b0;
            status_reg      <= 4'h0;
            mask_reg        <= 4'h0;
            reg_rdata_o     <= 4'h0;
            output_enable_o <= 1'b0;
            test_running_o  <= 1'b0;
            fault_o         <= 1'b0;
            warn_msg_o      <= 1'b0;
            indicator_o     <= 1'b0;
            buzzer_o        <= 1'b0;
            program_sel_o   <= 6'h01;
            irq_o           <= 1'b0;
        end else begin
            state_reg <= state_next;
            en_d_reg  <= remote_contact_control_enable_i;
            // beep count: on, off, on, off; two tones in all
            if (state_reg == ST_RESET && state_next == ST_ANNC) begin
                beep_cnt_reg <= 2'h3;
                beep_on_reg  <= 1'b1;
            end else if (beep_done && beep_cnt_reg != 2'h0) begin
                beep_cnt_reg <= beep_cnt_reg - 2'h1;
                beep_on_reg  <= ~beep_on_reg;
            end else if (beep_done) begin
                beep_on_reg <= 1'b0;
            end
            buzzer_o    <= beep_on_reg & beep_busy;
            indicator_o <= (state_next == ST_ANNC) | (state_next == ST_TEST);
            // program select held during a test
            if (state_reg == ST_RESET) begin
                if (remote_contact_control_enable_i && sel_lvl != 3'h0) begin
                    program_sel_o <= slot_to_prog(sel_lvl);
                end else if (local_program_i != 6'h00 && local_program_i <= `RCI_LOCAL_MAX) begin
                    program_sel_o <= local_program_i;
                end
            end
            output_enable_o <= (state_next == ST_TEST) & il_closed;
            test_running_o  <= (state_next == ST_TEST);
            fault_o         <= (state_next == ST_FAULT) | !il_closed;
            warn_msg_o      <= warn_busy | refuse | abort;
            // status: set wins over write-one clear
            if (reg_wr_i && !reg_addr_i) begin
                status_reg <= (status_reg & ~reg_wdata_i) | events;
            end else begin
                status_reg <= status_reg | events;
            end
            if (reg_wr_i && reg_addr_i) begin
                mask_reg <= reg_wdata_i;
            end
            if (reg_rd_i) begin
                reg_rdata_o <= reg_addr_i ? mask_reg : status_reg;
            end else begin
                reg_rdata_o <= 4'h0;
            end
            irq_o <= |(status_reg & mask_reg);
        end
    end
endmodule // rci_top

/* File: rci_top_props.sv */
// assertion checker for the remote contact front end
`include "rci_defs.vh"
module rci_top_props #(
    parameter [31:0] DEBOUNCE_CYC = 4,
    parameter [31:0] WARN_CYC     = 20
) (
    input wire                   core_clk_i,
    input wire                   rst_n_i,
    input wire                   interlock_contact_i,
    input wire                   remote_contact_control_enable_i,
    input wire                   local_test_key_i,
    input wire                   output_enable_o,
    input wire                   test_running_o,
    input wire                   fault_o,
    input wire                   warn_msg_o,
    input wire                   indicator_o,
    input wire                   buzzer_o,
    input wire [`RCI_PROG_W-1:0] program_sel_o
);
    // margin covers two sync flops, the debounce and the state update
    localparam int LIM = DEBOUNCE_CYC + 6;
    reg [31:0] open_cnt;
    reg [31:0] warn_cnt;
    reg [31:0] key_cnt;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            open_cnt <= 32'h0000_0000;
            warn_cnt <= 32'h0000_0000;
            key_cnt  <= 32'h0000_0063;
        end else begin
            open_cnt <= interlock_contact_i ? 32'h0000_0000 : open_cnt + 32'h0000_0001;
            warn_cnt <= warn_msg_o ? warn_cnt + 32'h0000_0001 : 32'h0000_0000;
            key_cnt  <= local_test_key_i ? 32'h0000_0000 :
                        (key_cnt < 32'h0000_0063 ? key_cnt + 32'h0000_0001 : key_cnt);
        end
    end
    a_out_needs_run: assert property (output_enable_o |-> test_running_o)
        else $error("output on without a running test");
    a_open_no_out: assert property (open_cnt > LIM |-> !output_enable_o)
        else $error("output on with interlock open");
    a_open_no_run: assert property (open_cnt > LIM |-> !test_running_o)
        else $error("test running with interlock open");
    a_open_fault: assert property (open_cnt > LIM |-> fault_o)
        else $error("open interlock not flagged as fault");
    a_prog_range: assert property (program_sel_o != 0 && program_sel_o <= `RCI_LOCAL_MAX)
        else $error("program selection out of range");
    a_start_gated: assert property ($rose(test_running_o) |->
        $past(remote_contact_control_enable_i) || key_cnt < 32'h0000_0004)
        else $error("test started without a permitted source");
    a_warn_bound: assert property (warn_cnt <= WARN_CYC + 2)
        else $error("warning shown too long");
    a_abort_now: assert property ($fell(interlock_contact_i) && test_running_o |->
        ##[1:LIM] (!output_enable_o && warn_msg_o))
        else $error("interlock opening did not abort the test");
    a_buzz_ind: assert property (buzzer_o |-> indicator_o)
        else $error("buzzer without indicator");
    c_run: cover property ($rose(test_running_o));
    c_warn: cover property ($rose(warn_msg_o));
    c_buzz: cover property ($rose(buzzer_o));
endmodule // rci_top_props

bind rci_top rci_top_props #(
    .DEBOUNCE_CYC(DEBOUNCE_CYC),
    .WARN_CYC(WARN_CYC)
) u_props (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .interlock_contact_i(interlock_contact_i),
    .remote_contact_control_enable_i(remote_contact_control_enable_i),
    .local_test_key_i(local_test_key_i),
    .output_enable_o(output_enable_o),
    .test_running_o(test_running_o),
    .fault_o(fault_o),
    .warn_msg_o(warn_msg_o),
    .indicator_o(indicator_o),
    .buzzer_o(buzzer_o),
    .program_sel_o(program_sel_o)
);

/* File: rci_plc_model.sv */
// external controller driving the contact lines
module rci_plc_model (
    input  wire       core_clk_i,
    output reg        test_c_o = 1'b0,
    output reg        reset_c_o = 1'b0,
    output reg        lock_c_o = 1'b0,
    output reg  [2:0] sel_c_o = 3'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    // momentary closure held n cycles; k 0 is test, else reset
    task hit(input int k, input int n);
        @(posedge core_clk_i);
        if (k == 0) test_c_o <= 1'b1;
        else reset_c_o <= 1'b1;
        repeat (n) @(posedge core_clk_i);
        test_c_o <= 1'b0;
        reset_c_o <= 1'b0;
    endtask
    task lock(input logic v);
        @(posedge core_clk_i);
        lock_c_o <= v;
    endtask
    task pick(input logic [2:0] v);
        @(posedge core_clk_i);
        sel_c_o <= v;
    endtask
endmodule // rci_plc_model

/* File: tb.sv */
// testbench for the remote contact front end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DB = 4;
    localparam int WN = 20;
    reg        core_clk_i = 0;
    reg        rst_n_i = 0;
    reg        en = 0, fkey = 0, ltest = 0, lrst = 0, tdone = 0, fdet = 0;
    reg        addr = 0, wr = 0, rd = 0;
    reg  [3:0] wdata = 4'h0;
    reg  [5:0] lprog = 6'h00;
    wire       tc, rc, lc, oe, run, flt, warn, ind, buz, irq;
    wire [2:0] sc;
    wire [3:0] rdata;
    wire [5:0] psel;
    int        failures = 0;
    int        num_checks = 0;
    initial forever #2 core_clk_i = ~core_clk_i;
    rci_plc_model plc (.core_clk_i(core_clk_i), .test_c_o(tc), .reset_c_o(rc), .lock_c_o(lc), .sel_c_o(sc));
    rci_top #(.DEBOUNCE_CYC(DB), .WARN_CYC(WN), .BEEP_CYC(5)) dut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .test_contact_i(tc), .reset_contact_i(rc),
        .interlock_contact_i(lc), .select_contact_i(sc), .remote_contact_control_enable_i(en),
        .front_key_i(fkey), .local_test_key_i(ltest), .local_reset_key_i(lrst), .local_program_i(lprog),
        .test_complete_i(tdone), .fault_detect_i(fdet), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .output_enable_o(oe), .test_running_o(run),
        .fault_o(flt), .warn_msg_o(warn), .indicator_o(ind), .buzzer_o(buz), .program_sel_o(psel), .irq_o(irq));
    task chk(input logic c, input string m);
        num_checks++;
        if (c !== 1'b1) begin
            failures++;
            $display("Error %0t: %s", $time, m);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    // k: 0 test key, 1 reset key, 2 complete, 3 fault, 4 front key
    task pls(input int k);
        @(posedge core_clk_i);
        {fkey, fdet, tdone, lrst, ltest} <= 5'b00001 << k;
        @(posedge core_clk_i);
        {fkey, fdet, tdone, lrst, ltest} <= 5'b00000;
    endtask
    task rw(input logic a, input logic [3:0] d);
        @(posedge core_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge core_clk_i);
        wr <= 0;
    endtask
    task rr(input logic a, input logic [3:0] e);
        @(posedge core_clk_i);
        addr <= a;
        rd <= 1;
        @(posedge core_clk_i);
        rd <= 0;
        #1 chk(rdata === e, "register read");
    endtask
    task s_idle_and_disabled;
        wt(DB + 8);
        chk(oe === 0 && run === 0 && flt === 1 && psel === 6'h01, "idle unplugged");
        plc.lock(1);
        plc.pick(3'h3);
        wt(DB + 8);
        plc.hit(0, DB + 8);
        wt(2);
        chk(run === 0 && psel === 6'h01, "remote acted while disabled");
    endtask
    task s_announce;
        int r;
        logic p;
        r = 0;
        p = 0;
        @(posedge core_clk_i);
        en <= 1;
        wt(3);
        chk(ind === 1, "indicator on enable");
        repeat (30) begin
            wt(1);
            if (buz && !p) r++;
            p = buz;
        end
        chk(r == 2, "two beeps");
        pls(4);
        wt(3);
        chk(ind === 0, "front key returns to reset");
    endtask
    task s_select;
        for (int v = 1; v < 8; v++) begin
            plc.pick(v[2:0]);
            wt(DB + 6);
            chk(psel === {3'h0, v[2:0]}, "remote program select");
        end
        plc.pick(3'h0);
        lprog <= 6'h32;
        wt(DB + 6);
        chk(psel === 6'h32, "local program fifty");
        @(posedge core_clk_i);
        lprog <= 6'h33;
        wt(4);
        chk(psel === 6'h32, "local program above fifty taken");
    endtask
    task s_run;
        fork
            plc.hit(0, DB + 30);
            begin
                wt(DB + 6);
                chk(run === 1 && oe === 1, "remote start");
                pls(2);
                wt(DB + 10);
                chk(run === 0, "held contact restarted");
            end
        join
        wt(DB + 6);
        pls(0);
        wt(3);
        pls(3);
        wt(3);
        chk(flt === 1 && oe === 0, "fault during test");
        plc.hit(1, DB + 4);
        wt(4);
        chk(flt === 0 && run === 0, "remote reset clears fault");
        pls(0);
        wt(3);
        pls(3);
        pls(1);
        wt(3);
        chk(flt === 0, "local reset clears fault");
    endtask
    task s_refuse_abort;
        rw(0, 4'b1111);
        rw(1, 4'b0001);
        wt(2);
        chk(irq === 0, "irq before request");
        plc.lock(0);
        wt(DB + 6);
        plc.hit(0, DB + 4);
        wt(2);
        chk(run === 0 && warn === 1 && irq === 1, "start refused when open");
        rr(0, 4'b0101);
        rw(0, 4'b0001);
        wt(2);
        chk(irq === 0, "irq cleared");
        wt(WN + 4);
        chk(warn === 0, "warning length");
        plc.lock(1);
        wt(DB + 6);
        plc.hit(0, DB + 4);
        wt(2);
        rw(0, 4'b1111);
        chk(run === 1, "start with interlock closed");
        plc.lock(0);
        wt(DB + 5);
        chk(run === 0 && oe === 0 && warn === 1 && flt === 1, "abort on open");
        rr(0, 4'b1100);
    endtask
    task end_of_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #40000;
        failures++;
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge core_clk_i);
        rst_n_i <= 1;
        s_idle_and_disabled();
        s_announce();
        s_select();
        s_run();
        s_refuse_abort();
        end_of_test();
    end
endmodule // tb
